// ==== src/lp_sync.sv ====
/*
 * line-printer synchronizer: instruction decode, band-to-buffer transfer,
 * paper feed and print sequencing, panel lamps, APB registers.
 * assumes all inputs synchronous to REF_CLK and a one-cycle BUF_WR sink.
 */
// How it works
// - decode only print-line and paper-feed codes
// - band digits select band copied into buffer
// - line digits give feed count, at most 79
// - clear instruction once transfer finishes
// - print one line after feed completes
// - feed-only code neither loads nor prints
// - load counter, release brake, engage clutch
// - feeding stops when counter reaches zero
// - search band, advance only if available
// - buffer load lasts three drum revolutions
// - feeding starts during buffer load
// - read unprimed part, then primed part
// - fresh check bit per character kept
// - word written three places before next fetch
// - after 13 words, clear and flag loaded
// - counter reloads with 51 to start print
// - print from current character, full revolution
// - clear button clears sequencing state and lamps; online bit and holding registers kept
// - code wheel check error sets lamp
// - flag charge fire and extinguish timeouts
// - space button feeds one line; feed-error lamp
// - off-normal lamp shows any abnormal condition
// - each index drum pulse is one line
// - character count ends printing at zero
module lp_sync
   import lp_sync_pkg::*;
#(
   parameter int FIRE_TIMEOUT = lp_sync_pkg::FIRE_CYC,
   parameter int EXT_TIMEOUT  = lp_sync_pkg::EXT_CYC,
   parameter int FEED_TIMEOUT = lp_sync_pkg::FEED_CYC
)
(
   // clock and reset
   input  wire logic        REF_CLK,
   input  wire logic        RST_N,
   input  wire logic        CE,
   // apb slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // processor static register
   input  wire logic        INSTR_VALID,
   input  wire logic [7:0]  INSTR_CODE,
   input  wire logic [3:0]  BAND_SELECT_DIGIT_HIGH,
   input  wire logic [3:0]  BAND_SELECT_DIGIT_LOW,
   input  wire logic [3:0]  LINE_COUNT_DIGIT_HIGH,
   input  wire logic [3:0]  LINE_COUNT_DIGIT_LOW,
   input  wire logic        BAND_FOUND,
   input  wire logic        DRUM_REV,
   output logic             INSTR_CLEAR,
   output logic             PRINTER_BUSY,
   // main-storage read
   output logic             MEM_RD,
   output logic      [7:0]  MEM_BAND,
   output logic      [7:0]  MEM_LOC,
   input  wire logic [39:0] MEM_DATA,
   input  wire logic        MEM_ACK,
   // print buffer write
   output logic             BUF_WR,
   output logic      [3:0]  BUF_WORD,
   output logic      [1:0]  BUF_PLACE,
   output logic      [69:0] BUF_DATA,
   output logic             BUF_LOADED,
   // printer mechanism
   input  wire logic        INDEX_PULSE,
   input  wire logic        CHAR_PULSE,
   input  wire logic        CODE_WHEEL_VALID,
   input  wire logic [6:0]  CODE_WHEEL_CODE,
   input  wire logic        CHARGE_TRIG,
   input  wire logic        CHARGE_FIRED,
   input  wire logic        CHARGE_OFF,
   output logic             FEED_CLUTCH,
   output logic             FEED_BRAKE,
   output logic             PRINT_ACTIVE,
   // operator panel
   input  wire logic        CLEAR_BTN,
   input  wire logic        SPACE_BTN,
   input  wire logic        NO_PAPER,
   input  wire logic        NO_RIBBON,
   input  wire logic        AIR_FLOW_LOW,
   input  wire logic        OVERHEAT,
   output logic             CHARGE_FIRE_TIMEOUT_LAMP,
   output logic             CHARGE_EXT_TIMEOUT_LAMP,
   output logic             CODE_WHEEL_LAMP,
   output logic             PAPER_FEED_LAMP,
   output logic             OFF_NORMAL_LAMP
);
   import lp_sync_pkg::*;

   // ==========================================================
   // state
   typedef enum logic [5:0] {
      LD_IDLE   = 6'b000001,
      LD_SEARCH = 6'b000010,
      LD_RD_A   = 6'b000100,
      LD_RD_X   = 6'b001000,
      LD_WR     = 6'b010000,
      LD_REVS   = 6'b100000
   } load_t;

   typedef enum logic [3:0] {
      FP_IDLE  = 4'b0001,
      FP_FEED  = 4'b0010,
      FP_WAIT  = 4'b0100,
      FP_PRINT = 4'b1000
   } feed_t;

   typedef enum logic [2:0] {
      CH_IDLE = 3'b001,
      CH_FIRE = 3'b010,
      CH_EXT  = 3'b100
   } charge_t;

   load_t        ld;
   feed_t        fp;
   charge_t      ch;
   logic [3:0]   word_idx;
   logic [1:0]   rev_cnt;
   logic [39:0]  reg_a;
   logic [6:0]   cnt;
   logic         print_due;
   logic         online;
   logic         lamp_clr;
   logic         space_prev;
   logic [31:0]  fault_tmr;
   logic [31:0]  feed_tmr;
   logic [9:0]   checks;
   logic         any_fault;
   logic         busy;
   logic         take_print;
   logic         take_feed;
   logic         manual_feed;
   logic         load_done;
   logic         in_step2;
   logic         apb_setup;
   logic         apb_wr;
   logic [31:0]  next_rdata;
   logic         next_err;

   // ==========================================================
   // decode
   assign any_fault = CHARGE_FIRE_TIMEOUT_LAMP | CHARGE_EXT_TIMEOUT_LAMP | CODE_WHEEL_LAMP
                    | PAPER_FEED_LAMP | NO_PAPER | NO_RIBBON | AIR_FLOW_LOW | OVERHEAT;
   // a loaded but unprinted buffer still counts as busy
   assign busy        = (fp != FP_IDLE) | print_due;
   assign take_print  = (ld == LD_SEARCH) & BAND_FOUND & ~busy & ~any_fault & online;
   assign take_feed   = (ld == LD_IDLE) & INSTR_VALID & (INSTR_CODE == OP_PAPER_FEED)
                      & (fp == FP_IDLE) & online & ~INSTR_CLEAR;
   assign manual_feed = SPACE_BTN & ~space_prev & (fp == FP_IDLE) & (ld == LD_IDLE);
   assign in_step2    = (ld == LD_RD_A) | (ld == LD_RD_X) | (ld == LD_WR) | (ld == LD_REVS);
   assign load_done   = (ld == LD_REVS) & (rev_cnt == LOAD_REVS);

   // fresh check bit per character from both parts
   generate
      for (genvar i = 0; i < 10; i++)
      begin : g_chk
         assign checks[i] = odd_check({MEM_DATA[2*i+1:2*i], reg_a[4*i+3:4*i]});
      end
   endgenerate

   // ==========================================================
   // band search and buffer load
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         ld       <= LD_IDLE;
         word_idx <= 4'h0;
         MEM_RD   <= 1'b0;
         MEM_BAND <= 8'h00;
         MEM_LOC  <= 8'h00;
         BUF_WR   <= 1'b0;
         BUF_WORD <= 4'h0;
         BUF_PLACE <= 2'h0;
      end
      else if (CE)
      begin
         if (CLEAR_BTN)
         begin
            ld       <= LD_IDLE;
            word_idx <= 4'h0;
            MEM_RD   <= 1'b0;
            BUF_WR   <= 1'b0;
            BUF_PLACE <= 2'h0;
         end
         else
         begin
            unique case (ld)
               LD_IDLE:
                  if (INSTR_VALID && INSTR_CODE == OP_PRINT_LINE && !INSTR_CLEAR)
                  begin
                     ld       <= LD_SEARCH;
                     MEM_BAND <= {BAND_SELECT_DIGIT_HIGH, BAND_SELECT_DIGIT_LOW};
                  end
               LD_SEARCH:
                  if (take_print)
                  begin
                     ld       <= LD_RD_A;
                     word_idx <= 4'h0;
                     MEM_LOC  <= WORD_LOC[0];
                     MEM_RD   <= 1'b1;
                  end
               LD_RD_A:
                  if (MEM_ACK)
                  begin
                     ld      <= LD_RD_X;
                     MEM_LOC <= WORD_LOC[word_idx] + PRIMED_OFFSET;
                  end
               LD_RD_X:
                  if (MEM_ACK)
                  begin
                     ld        <= LD_WR;
                     MEM_RD    <= 1'b0;
                     BUF_WR    <= 1'b1;
                     BUF_WORD  <= word_idx;
                     BUF_PLACE <= 2'h0;
                  end
               LD_WR:
                  if (BUF_PLACE == BUF_PLACES - 2'h1)
                  begin
                     BUF_WR <= 1'b0;
                     if (word_idx == WORD_COUNT - 4'h1)
                        ld <= LD_REVS;
                     else
                     begin
                        ld       <= LD_RD_A;
                        word_idx <= word_idx + 4'h1;
                        MEM_LOC  <= WORD_LOC[word_idx + 4'h1];
                        MEM_RD   <= 1'b1;
                     end
                  end
                  else
                     BUF_PLACE <= BUF_PLACE + 2'h1;
               LD_REVS:
                  if (load_done)
                     ld <= LD_IDLE;
            endcase
         end
      end
   end

   // holding registers
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         reg_a    <= 40'h0;
         BUF_DATA <= 70'h0;
      end
      else if (CE)
      begin
         if (ld == LD_RD_A && MEM_ACK)
            reg_a <= MEM_DATA;
         if (ld == LD_RD_X && MEM_ACK)
         begin
            // upper 30 bits double as the second holding register
            BUF_DATA <= {checks, MEM_DATA[19:0], reg_a};
         end
      end
   end

   // drum revolutions spent in step two
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
         rev_cnt <= 2'h0;
      else if (CE)
      begin
         if (CLEAR_BTN || !in_step2)
            rev_cnt <= 2'h0;
         else if (DRUM_REV && rev_cnt != LOAD_REVS)
            rev_cnt <= rev_cnt + 2'h1;
      end
   end

   // instruction release and buffer-loaded flag
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         INSTR_CLEAR <= 1'b0;
         BUF_LOADED  <= 1'b0;
      end
      else if (CE)
      begin
         INSTR_CLEAR <= ~CLEAR_BTN & (load_done | take_feed);
         if (CLEAR_BTN)
            BUF_LOADED <= 1'b0;
         else if (load_done)
            BUF_LOADED <= 1'b1;
         else if (fp == FP_PRINT)
            BUF_LOADED <= 1'b0;
      end
   end

   // ==========================================================
   // paper feed and printing
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         fp           <= FP_IDLE;
         cnt          <= 7'h0;
         print_due    <= 1'b0;
         FEED_CLUTCH  <= 1'b0;
         FEED_BRAKE   <= 1'b1;
         PRINT_ACTIVE <= 1'b0;
      end
      else if (CE)
      begin
         if (CLEAR_BTN)
         begin
            fp           <= FP_IDLE;
            cnt          <= 7'h0;
            print_due    <= 1'b0;
            FEED_CLUTCH  <= 1'b0;
            FEED_BRAKE   <= 1'b1;
            PRINT_ACTIVE <= 1'b0;
         end
         else
         begin
            unique case (fp)
               FP_IDLE:
                  if (take_print || take_feed || manual_feed)
                  begin
                     fp          <= FP_FEED;
                     print_due   <= take_print;
                     cnt         <= manual_feed ? 7'h1
                                  : bcd_lines(LINE_COUNT_DIGIT_HIGH, LINE_COUNT_DIGIT_LOW);
                     FEED_CLUTCH <= 1'b1;
                     FEED_BRAKE  <= 1'b0;
                  end
               FP_FEED:
                  if (cnt == 7'h0 || (cnt == 7'h1 && INDEX_PULSE))
                  begin
                     FEED_CLUTCH <= 1'b0;
                     FEED_BRAKE  <= 1'b1;
                     cnt         <= CHAR_COUNT;
                     fp          <= print_due ? FP_WAIT : FP_IDLE;
                  end
                  else if (INDEX_PULSE)
                     cnt <= cnt - 7'h1;
               FP_WAIT:
                  // feed may outrun a slow band transfer
                  if (BUF_LOADED)
                  begin
                     fp           <= FP_PRINT;
                     print_due    <= 1'b0;
                     PRINT_ACTIVE <= 1'b1;
                  end
               FP_PRINT:
                  if (cnt == 7'h1 && CHAR_PULSE)
                  begin
                     cnt          <= 7'h0;
                     PRINT_ACTIVE <= 1'b0;
                     fp           <= FP_IDLE;
                  end
                  else if (CHAR_PULSE)
                     cnt <= cnt - 7'h1;
            endcase
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
         PRINTER_BUSY <= 1'b0;
      else if (CE)
         PRINTER_BUSY <= ~CLEAR_BTN & (busy | in_step2);
   end

   // ==========================================================
   // panel button edge
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
         space_prev <= 1'b0;
      else if (CE)
         space_prev <= SPACE_BTN;
   end

   // ==========================================================
   // charge tube supervision
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         ch                       <= CH_IDLE;
         fault_tmr                <= 32'h0;
         CHARGE_FIRE_TIMEOUT_LAMP <= 1'b0;
         CHARGE_EXT_TIMEOUT_LAMP  <= 1'b0;
      end
      else if (CE)
      begin
         if (CLEAR_BTN)
         begin
            ch                       <= CH_IDLE;
            fault_tmr                <= 32'h0;
            CHARGE_FIRE_TIMEOUT_LAMP <= 1'b0;
            CHARGE_EXT_TIMEOUT_LAMP  <= 1'b0;
         end
         else
         begin
            // set wins over a software lamp clear in the same cycle
            if (lamp_clr)
            begin
               CHARGE_FIRE_TIMEOUT_LAMP <= 1'b0;
               CHARGE_EXT_TIMEOUT_LAMP  <= 1'b0;
            end
            unique case (ch)
               CH_IDLE:
                  if (CHARGE_TRIG)
                  begin
                     ch        <= CH_FIRE;
                     fault_tmr <= 32'h0;
                  end
               CH_FIRE:
                  if (CHARGE_FIRED)
                  begin
                     ch        <= CH_EXT;
                     fault_tmr <= 32'h0;
                  end
                  else if (fault_tmr == 32'(FIRE_TIMEOUT - 1))
                  begin
                     CHARGE_FIRE_TIMEOUT_LAMP <= 1'b1;
                     ch                       <= CH_IDLE;
                  end
                  else
                     fault_tmr <= fault_tmr + 32'h1;
               CH_EXT:
                  if (CHARGE_OFF)
                     ch <= CH_IDLE;
                  else if (fault_tmr == 32'(EXT_TIMEOUT - 1))
                  begin
                     CHARGE_EXT_TIMEOUT_LAMP <= 1'b1;
                     ch                      <= CH_IDLE;
                  end
                  else
                     fault_tmr <= fault_tmr + 32'h1;
            endcase
         end
      end
   end

   // ==========================================================
   // code wheel check and paper feed error
   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         CODE_WHEEL_LAMP <= 1'b0;
         PAPER_FEED_LAMP <= 1'b0;
         feed_tmr        <= 32'h0;
         OFF_NORMAL_LAMP <= 1'b0;
      end
      else if (CE)
      begin
         if (CLEAR_BTN)
         begin
            CODE_WHEEL_LAMP <= 1'b0;
            PAPER_FEED_LAMP <= 1'b0;
            feed_tmr        <= 32'h0;
            OFF_NORMAL_LAMP <= 1'b0;
         end
         else
         begin
            if (CODE_WHEEL_VALID && odd_check(CODE_WHEEL_CODE[5:0]) != CODE_WHEEL_CODE[6])
               CODE_WHEEL_LAMP <= 1'b1;
            else if (lamp_clr)
               CODE_WHEEL_LAMP <= 1'b0;
            // no index pulse for too long while the clutch is in
            if (fp != FP_FEED || INDEX_PULSE)
               feed_tmr <= 32'h0;
            else if (feed_tmr != 32'(FEED_TIMEOUT - 1))
               feed_tmr <= feed_tmr + 32'h1;
            if (fp == FP_FEED && feed_tmr == 32'(FEED_TIMEOUT - 1))
               PAPER_FEED_LAMP <= 1'b1;
            else if (lamp_clr)
               PAPER_FEED_LAMP <= 1'b0;
            OFF_NORMAL_LAMP <= any_fault;
         end
      end
   end

   // ==========================================================
   // apb registers, answered in the first access cycle
   assign apb_setup = PSEL & ~PENABLE;
   assign apb_wr    = PSEL & PENABLE & PREADY & PWRITE;

   always_comb
   begin
      next_rdata = 32'h0;
      next_err   = 1'b0;
      unique case (PADDR)
         REG_CTRL:   next_rdata = {31'h0, online};
         REG_STATUS: next_rdata = {16'h0, ld, fp, OFF_NORMAL_LAMP, PAPER_FEED_LAMP, CODE_WHEEL_LAMP,
                                   CHARGE_EXT_TIMEOUT_LAMP, CHARGE_FIRE_TIMEOUT_LAMP, BUF_LOADED};
         REG_COUNT:  next_rdata = {19'h0, rev_cnt, word_idx, cnt};
         default:    next_err   = 1'b1;
      endcase
   end

   always_ff @(posedge REF_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         PRDATA   <= 32'h0;
         PREADY   <= 1'b0;
         PSLVERR  <= 1'b0;
         online   <= CTRL_RESET;
         lamp_clr <= 1'b0;
      end
      else if (CE)
      begin
         PREADY   <= apb_setup;
         PSLVERR  <= apb_setup & next_err;
         lamp_clr <= apb_wr & (PADDR == REG_CTRL) & PWDATA[CTRL_LAMP_CLR];
         if (apb_setup)
            PRDATA <= PWRITE ? 32'h0 : next_rdata;
         if (apb_wr && PADDR == REG_CTRL)
            online <= PWDATA[CTRL_ONLINE];
      end
   end

endmodule

// ==== src/lp_sync_pkg.sv ====
/*
 * constants shared by the line-printer synchronizer: instruction codes,
 * band word locations, counts, timing and the register map.
 * assumes a 250 MHz reference clock and a 32-bit APB master.
 */
package lp_sync_pkg;

   // ==========================================================
   // instruction codes (two decimal digits, packed BCD)
   localparam logic [7:0] OP_PRINT_LINE  = 8'h11;
   localparam logic [7:0] OP_PAPER_FEED  = 8'h16;

   // ==========================================================
   // counts
   localparam logic [6:0] LINE_MAX       = 7'h4f;   // 79 lines
   localparam logic [6:0] CHAR_COUNT     = 7'h33;   // 51 typewheel characters
   localparam logic [3:0] WORD_COUNT     = 4'hd;    // 13 print words
   localparam logic [1:0] BUF_PLACES     = 2'h3;    // copies of each word
   localparam logic [1:0] LOAD_REVS      = 2'h3;    // drum revolutions of step two
   localparam logic [7:0] PRIMED_OFFSET  = 8'h05;

   // unprimed word locations, word 1 first
   localparam logic [7:0] WORD_LOC [13] = '{8'd0, 8'd81, 8'd165, 8'd50, 8'd134, 8'd18, 8'd103,
                                            8'd41, 8'd125, 8'd9, 8'd94, 8'd178, 8'd62};

   // ==========================================================
   // timing
   localparam int CLK_MHZ          = 250;
   localparam int FIRE_TIME_NS     = 200000;
   localparam int EXT_TIME_NS      = 400000;
   localparam int FEED_TIME_NS     = 50000000;
   localparam int FIRE_CYC         = FIRE_TIME_NS * CLK_MHZ / 1000;
   localparam int EXT_CYC          = EXT_TIME_NS * CLK_MHZ / 1000;
   localparam int FEED_CYC         = FEED_TIME_NS / 1000 * CLK_MHZ;

   // ==========================================================
   // register map
   localparam logic [7:0] REG_CTRL       = 8'h00;
   localparam logic [7:0] REG_STATUS     = 8'h04;
   localparam logic [7:0] REG_COUNT      = 8'h08;
   localparam int         CTRL_ONLINE    = 0;
   localparam int         CTRL_LAMP_CLR  = 1;
   localparam logic       CTRL_RESET     = 1'b1;

   // ==========================================================
   // helpers
   function automatic logic odd_check(input logic [5:0] code);
      return ~(^code);
   endfunction

   function automatic logic [6:0] bcd_lines(input logic [3:0] hi, input logic [3:0] lo);
      logic [7:0] v;
      v = 8'(hi) * 8'h0a + 8'(lo);
      return (v > 8'(LINE_MAX)) ? LINE_MAX : v[6:0];
   endfunction

endpackage

// ==== verification/lp_sync_properties.sv ====
/* assertions on the top ports of lp_sync.
   assumes the bind below reaches every lp_sync instance. */
module lp_sync_properties(
   // clock, reset and panel
   input wire logic       REF_CLK, RST_N, CLEAR_BTN, NO_PAPER, OFF_NORMAL_LAMP,
   // feed, print, storage and buffer
   input wire logic       FEED_CLUTCH, FEED_BRAKE, PRINT_ACTIVE, PRINTER_BUSY, MEM_RD, MEM_ACK, BUF_WR,
   input wire logic [7:0] MEM_LOC,
   input wire logic [1:0] BUF_PLACE,
   // code wheel
   input wire logic       CODE_WHEEL_VALID, CODE_WHEEL_LAMP,
   input wire logic [6:0] CODE_WHEEL_CODE
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   // ==========================================================
   // sequences
   sequence s_places;
      BUF_PLACE == 2'h0 ##1 BUF_WR && BUF_PLACE == 2'h1 ##1 BUF_WR && BUF_PLACE == 2'h2 ##1 !BUF_WR;
   endsequence
   // ==========================================================
   // properties
   a_three_places: assert property ($rose(BUF_WR) |-> s_places) else $error("word places wrong");
   a_clutch_brake: assert property (FEED_CLUTCH |-> !FEED_BRAKE) else $error("clutch on brake");
   a_read_held: assert property (MEM_RD && !MEM_ACK && !CLEAR_BTN |=> MEM_RD && $stable(MEM_LOC))
      else $error("read dropped");
   a_clear_idle: assert property (CLEAR_BTN |=> !PRINTER_BUSY && !PRINT_ACTIVE) else $error("clear ignored");
   a_print_stop: assert property (PRINT_ACTIVE |-> !FEED_CLUTCH) else $error("print while feeding");
   a_print_busy: assert property (PRINT_ACTIVE |-> PRINTER_BUSY) else $error("print not busy");
   a_parity_lamp: assert property (CODE_WHEEL_VALID && !(^CODE_WHEEL_CODE) && !CLEAR_BTN |=> CODE_WHEEL_LAMP)
      else $error("parity lamp off");
   a_fault_lamp: assert property (NO_PAPER && !CLEAR_BTN |=> OFF_NORMAL_LAMP) else $error("fault lamp off");
endmodule
bind lp_sync lp_sync_properties chk (.*);

// ==== verification/lp_mem_model.sv ====
/* storage side of the processor: answers held reads.
   assumes reads are held until acknowledged. */
module lp_mem_model(
   input  wire logic        clk, rst_n, rd,
   input  wire logic [7:0]  loc,
   output logic             ack,
   output logic      [39:0] data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] w;
   // odd locations answer late; idle data toggles so nothing stale looks valid
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         w <= 3'h0;
         ack <= 1'b0;
         data <= 40'h0;
      end
      else
      begin
         ack <= 1'b0;
         data <= ~data;
         if (rd && !ack && w == {loc[0], 2'h0})
         begin
            ack <= 1'b1;
            data <= {5{loc}};
            w <= 3'h0;
         end
         else if (rd && !ack)
            w <= w + 3'h1;
      end
   end
endmodule

// ==== verification/tb_line_printer_synchronizer.sv ====
/* self-checking bench for lp_sync with a storage model.
   assumes shortened timeouts of 20, 40 and 200 cycles. */
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; $display("ERROR %0t got %0h exp %0h", $time, a, b); end end
module tb_line_printer_synchronizer;
   import lp_sync_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic REF_CLK = 0, RST_N = 0, CE = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, INSTR_VALID = 0, BAND_FOUND = 0;
   logic DRUM_REV = 0, INDEX_PULSE = 0, CHAR_PULSE = 0, CODE_WHEEL_VALID = 0, CHARGE_TRIG = 0, CHARGE_FIRED = 0;
   logic CHARGE_OFF = 0, CLEAR_BTN = 0, SPACE_BTN = 0, NO_PAPER = 0, NO_RIBBON = 0, AIR_FLOW_LOW = 0, OVERHEAT = 0;
   logic [3:0] BAND_SELECT_DIGIT_HIGH = 0, BAND_SELECT_DIGIT_LOW = 0, LINE_COUNT_DIGIT_HIGH = 0, LINE_COUNT_DIGIT_LOW = 0;
   logic [7:0] PADDR = 0, INSTR_CODE = 0, MEM_BAND, MEM_LOC;
   logic [31:0] PWDATA = 0, PRDATA, rd;
   logic [6:0] CODE_WHEEL_CODE = 0;
   logic [39:0] MEM_DATA;
   logic [69:0] BUF_DATA;
   logic [3:0] BUF_WORD;
   logic [1:0] BUF_PLACE, ph = 0;
   logic PREADY, PSLVERR, INSTR_CLEAR, PRINTER_BUSY, MEM_RD, MEM_ACK, BUF_WR, BUF_LOADED, FEED_CLUTCH, FEED_BRAKE, er;
   logic PRINT_ACTIVE, CHARGE_FIRE_TIMEOUT_LAMP, CHARGE_EXT_TIMEOUT_LAMP, CODE_WHEEL_LAMP, PAPER_FEED_LAMP, OFF_NORMAL_LAMP;
   int n_errors = 0, tests_run = 0, ni = 0, nc = 0, nw = 0;
   typedef struct {logic sp; logic [3:0] h, l; int n;} row_t;
   row_t rows [4] = '{'{0, 0, 3, 3}, '{0, 1, 2, 12}, '{0, 9, 9, 79}, '{1, 0, 0, 1}};
   lp_sync #(.FIRE_TIMEOUT(20), .EXT_TIMEOUT(40), .FEED_TIMEOUT(200)) dut (.*);
   lp_mem_model mem (.clk(REF_CLK), .rst_n(RST_N), .rd(MEM_RD), .loc(MEM_LOC), .ack(MEM_ACK), .data(MEM_DATA));
   always #2 REF_CLK = ~REF_CLK;
   // ==========================================================
   // mechanism pulses and buffer monitor
   always @(posedge REF_CLK)
   begin
      ph <= ph + 2'h1;
      DRUM_REV <= ph == 2'h0;
      INDEX_PULSE <= FEED_CLUTCH && ph == 2'h3;
      CHAR_PULSE <= PRINT_ACTIVE && ph == 2'h1;
      ni += INDEX_PULSE;
      nc += CHAR_PULSE;
      if (BUF_WR && BUF_PLACE == 2'h0)
      begin
         `CHK(BUF_DATA[39:0], {5{WORD_LOC[nw / 3]}})
         `CHK(BUF_DATA[59:40], 20'({5{WORD_LOC[nw / 3] + PRIMED_OFFSET}}))
         `CHK(BUF_WORD, 4'(nw / 3))
         for (int i = 0; i < 10; i++)
            `CHK(^{BUF_DATA[60 + i], BUF_DATA[40 + 2 * i +: 2], BUF_DATA[4 * i +: 4]}, 1'b1)
      end
      nw += BUF_WR;
   end
   function automatic logic pick(input int s);
      return s == 0 ? FEED_CLUTCH : s == 2 ? PRINT_ACTIVE : s == 3 ? INSTR_CLEAR : PREADY;
   endfunction
   task complete_run;
      if (n_errors == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task wt(input int s, input logic v);
      for (int k = 0; k < 3000; k++)
      begin
         @(posedge REF_CLK);
         if (pick(s) === v) return;
      end
      n_errors++;
      $display("ERROR %0t timeout", $time);
      complete_run();
   endtask
   task apb(input logic w, input logic [7:0] a);
      @(posedge REF_CLK);
      {PSEL, PENABLE, PWRITE, PADDR} <= {2'b10, w, a};
      @(posedge REF_CLK);
      PENABLE <= 1'b1;
      wt(4, 1'b1);
      {rd, er} = {PRDATA, PSLVERR};
      {PSEL, PENABLE} <= 2'b00;
   endtask
   initial
   begin
      repeat (20) @(posedge REF_CLK);
      RST_N <= 1'b1;
      apb(0, REG_CTRL);
      `CHK(rd, 32'h1)
      apb(1, 8'h0c);
      `CHK(er, 1'b1)
      foreach (rows[i])
      begin
         ni = 0;
         {LINE_COUNT_DIGIT_HIGH, LINE_COUNT_DIGIT_LOW, INSTR_CODE} <= {rows[i].h, rows[i].l, OP_PAPER_FEED};
         {INSTR_VALID, SPACE_BTN} <= {!rows[i].sp, rows[i].sp};
         wt(0, 1'b1);
         `CHK(INSTR_CLEAR, !rows[i].sp)
         {INSTR_VALID, SPACE_BTN} <= 2'b00;
         wt(0, 1'b0);
         repeat (4) @(posedge REF_CLK);
         `CHK(ni, rows[i].n)
         `CHK(nc, 0)
      end
      {ni, nw} = 0;
      {BAND_SELECT_DIGIT_LOW, LINE_COUNT_DIGIT_HIGH, LINE_COUNT_DIGIT_LOW, INSTR_CODE} <= {8'h70, 4'h2, OP_PRINT_LINE};
      {INSTR_VALID, BAND_FOUND} <= 2'b11;
      wt(3, 1'b1);
      `CHK(MEM_BAND, 8'h07)
      {INSTR_VALID, BAND_FOUND} <= 2'b00;
      `CHK(nw, 39)
      `CHK(ni, 2)
      wt(2, 1'b1);
      wt(2, 1'b0);
      `CHK(nc, 51)
      `CHK(BUF_LOADED, 1'b0)
      {CODE_WHEEL_VALID, NO_PAPER, CHARGE_TRIG} <= 3'b111;
      @(posedge REF_CLK);
      {CODE_WHEEL_VALID, CHARGE_TRIG} <= 2'b00;
      repeat (30) @(posedge REF_CLK);
      {CHARGE_TRIG, CHARGE_FIRED} <= 2'b11;
      @(posedge REF_CLK);
      CHARGE_TRIG <= 1'b0;
      repeat (45) @(posedge REF_CLK);
      `CHK({CODE_WHEEL_LAMP, OFF_NORMAL_LAMP, CHARGE_FIRE_TIMEOUT_LAMP, CHARGE_EXT_TIMEOUT_LAMP}, 4'hf)
      {NO_PAPER, CLEAR_BTN, CHARGE_FIRED} <= 3'h2;
      repeat (3) @(posedge REF_CLK);
      CLEAR_BTN <= 1'b0;
      repeat (3) @(posedge REF_CLK);
      `CHK({CODE_WHEEL_LAMP, CHARGE_FIRE_TIMEOUT_LAMP, CHARGE_EXT_TIMEOUT_LAMP}, 3'h0)
      // lamp set again, then cleared by software together with going offline
      {CODE_WHEEL_VALID, PWDATA} <= {1'b1, 32'h2};
      apb(1, REG_CTRL);
      CODE_WHEEL_VALID <= 1'b0;
      apb(0, REG_CTRL);
      `CHK(rd, 32'h0)
      `CHK(CODE_WHEEL_LAMP, 1'b0)
      // reset in mid-run brings the printer back online
      RST_N <= 1'b0;
      repeat (2) @(posedge REF_CLK);
      RST_N <= 1'b1;
      apb(0, REG_CTRL);
      `CHK(rd, 32'h1)
      complete_run();
   end
endmodule
